/* dv/rwd_far_model.sv */
// far side: channel-check wire with pull-up and one bus card
`timescale 1ns/10ps
module rwd_far_model (
  // pullers of the wire
  input wire logic i_card_pull,
  input wire logic i_chk_oe,
  input wire logic i_chk_n,
  // resolved wire level
  output logic o_wire_n
);
  // open drain: any puller wins, pull-up otherwise
  assign o_wire_n = ((i_chk_oe && !i_chk_n) || i_card_pull) ? 1'b0 : 1'b1;
endmodule : rwd_far_model

/* dv/rwd_top_props.sv */
// assertion checker for the alarm watchdog top
`timescale 1ns/10ps
module rwd_top_props #(
  parameter int unsigned RST_CYCLES = 5
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // watched ports
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_timer2_out,
  input wire logic o_timer2_gate,
  input wire logic o_speaker,
  input wire logic i_wd_cmd_valid,
  input wire logic i_wd_cmd_enable,
  input wire rwd_pkg::rwd_sec_t i_wd_cmd_seconds,
  input wire logic o_wd_running,
  input wire logic o_chk_line_oe,
  input wire logic o_irq8,
  input wire logic o_nmi,
  input wire logic o_sys_reset
);
  logic port_wr;
  logic [11:0] hi_cnt;
  logic [11:0] next_hi_cnt;
  assign port_wr = i_io_wr && (i_io_addr == 16'h0061);
  // length of the current reset pulse
  always_comb next_hi_cnt = o_sys_reset ? hi_cnt + 12'h001 : 12'h000;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) hi_cnt <= 12'h000;
    else hi_cnt <= next_hi_cnt;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence wd_go;
    i_wd_cmd_valid && i_wd_cmd_enable && (i_wd_cmd_seconds != 8'h00);
  endsequence
  sequence wd_halt;
    i_wd_cmd_valid && !(i_wd_cmd_enable && (i_wd_cmd_seconds != 8'h00));
  endsequence
  gate_follows_a: assert property (port_wr |=> o_timer2_gate == $past(i_io_wdata[0]))
    else $error("timer gate wrong");
  // speaker lags the gate by one cycle, so compare with the gate it was built from
  speaker_and_a: assert property (o_speaker |-> !$past(o_timer2_gate) || $past(i_timer2_out))
    else $error("speaker not gated");
  irq_pulse_a: assert property (o_irq8 |=> !o_irq8)
    else $error("irq pulse too long");
  nmi_pulse_a: assert property (o_nmi |=> !o_nmi)
    else $error("nmi pulse too long");
  chk_drive_a: assert property ($rose(o_chk_line_oe) |-> o_irq8)
    else $error("check line not at expiry");
  chk_hold_a: assert property (o_chk_line_oe && !(port_wr && i_io_wdata[3]) |=> o_chk_line_oe)
    else $error("check line released");
  reset_len_a: assert property ($fell(o_sys_reset) |-> hi_cnt >= RST_CYCLES)
    else $error("reset pulse short");
  run_start_a: assert property (wd_go |-> ##2 o_wd_running)
    else $error("watchdog not running");
  run_stop_a: assert property (wd_halt |-> ##2 !o_wd_running)
    else $error("watchdog not stopped");
endmodule : rwd_top_props

bind rwd_top rwd_top_props #(.RST_CYCLES(RST_CYCLES)) u_props (.*);

/* dv/rwd_top_tb.sv */
// self-checking bench for the alarm watchdog top
`timescale 1ns/10ps
module rwd_top_tb;
  import rwd_pkg::*;
  localparam int SEC = 20;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic [15:0] i_io_addr = 16'h0000;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic [7:0] i_io_wdata = 8'h00;
  logic [7:0] o_io_rdata;
  logic i_timer2_out = 1'b0;
  logic o_timer2_gate;
  logic o_speaker;
  logic i_wd_cmd_valid = 1'b0;
  logic i_wd_cmd_enable = 1'b0;
  rwd_sec_t i_wd_cmd_seconds = 8'h00;
  logic o_wd_running;
  rwd_boot_e i_boot_timeout_sel = RWD_BOOT_OFF;
  logic [1:0] i_timeout_route_jumper = 2'b00;
  logic i_reset_button_n = 1'b1;
  logic i_chk_line_n;
  logic o_chk_line_n;
  logic o_chk_line_oe;
  logic o_irq8;
  logic o_nmi;
  logic o_sys_reset;
  logic card_pull = 1'b0;
  logic rst_d = 1'b0;
  logic [7:0] code;
  logic [2:0] q[$];
  int err_total = 0;
  int checks_done = 0;
  int evt_n = 0;
  rwd_top #(.SEC_CYCLES(SEC), .DEBOUNCE_CYCLES(4), .RST_CYCLES(5)) dut (.*);
  rwd_far_model far (.i_card_pull(card_pull), .i_chk_oe(o_chk_line_oe),
    .i_chk_n(o_chk_line_n), .o_wire_n(i_chk_line_n));
  initial begin
    forever #20 i_clock = ~i_clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // each event cycle is matched against the oldest note
  always @(negedge i_clock) begin
    code = {5'h00, o_sys_reset && !rst_d, o_nmi, o_irq8};
    rst_d = o_sys_reset;
    if (code != 8'h00) begin
      evt_n++;
      check(code, {5'h00, q.size() > 0 ? q.pop_front() : 3'b000});
    end
  end
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    i_io_wr = wr;
    i_io_rd = !wr;
    i_io_addr = a;
    i_io_wdata = d;
    @(negedge i_clock);
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    @(negedge i_clock);
  endtask : io
  task automatic rd(input logic [7:0] exp);
    io(1'b0, 16'h0061, 8'h00);
    check(o_io_rdata, exp);
  endtask : rd
  task automatic cmd(input logic en, input rwd_sec_t s);
    i_wd_cmd_valid = 1'b1;
    i_wd_cmd_enable = en;
    i_wd_cmd_seconds = s;
    @(negedge i_clock);
    i_wd_cmd_valid = 1'b0;
    @(negedge i_clock);
  endtask : cmd
  // note an event, then demand it inside the window
  task automatic expect_evt(input logic [2:0] c, input int lo, input int hi);
    int n0;
    int t;
    n0 = evt_n;
    t = 0;
    q.push_back(c);
    while (evt_n == n0 && t < hi) begin
      @(negedge i_clock);
      t++;
    end
    check({7'h00, t >= lo && evt_n != n0}, 8'h01);
  endtask : expect_evt
  task automatic do_reset();
    i_arst_n = 1'b0;
    repeat (8) @(negedge i_clock);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clock);
  endtask : do_reset
  initial begin
    logic [7:0] d;
    int s;
    void'($urandom(32'h11ea));
    do_reset();
    rd(8'h28);
    for (int i = 0; i < 8; i++) begin
      d = {4'h0, 2'b10, i[1:0]};
      i_timer2_out = 1'($urandom);
      io(1'b1, 16'h0061, d);
      check({6'h00, o_timer2_gate, o_speaker}, {6'h00, d[0], d[1] & (!d[0] | i_timer2_out)});
      rd({2'b00, !d[0] | i_timer2_out, 1'b0, d[3:0]});
    end
    io(1'b1, 16'h0061, 8'h08);
    io(1'b1, 16'h0062, 8'h03);
    rd(8'h28);
    cmd(1'b1, 8'h02);
    expect_evt(3'b001, 2 * SEC - 4, 2 * SEC + 6);
    cmd(1'b1, 8'h02);
    repeat (30) @(negedge i_clock);
    cmd(1'b1, 8'h02);
    expect_evt(3'b001, 2 * SEC - 4, 2 * SEC + 6);
    for (int j = 0; j < 2; j++) begin
      s = j ? 255 : 1 + $urandom % 6;
      cmd(1'b1, 8'(s));
      expect_evt(3'b001, s * SEC - 4, s * SEC + 6);
    end
    cmd(1'b1, 8'h01);
    cmd(1'b0, 8'h01);
    repeat (40) @(negedge i_clock);
    i_timeout_route_jumper = 2'b01;
    io(1'b1, 16'h0061, 8'h00);
    cmd(1'b1, 8'h01);
    expect_evt(3'b001, SEC - 4, SEC + 6);
    expect_evt(3'b010, 1, 8);
    rd(8'h60);
    cmd(1'b1, 8'h01);
    expect_evt(3'b001, SEC - 4, SEC + 6);
    io(1'b1, 16'h0061, 8'h08);
    io(1'b1, 16'h0061, 8'h00);
    card_pull = 1'b1;
    expect_evt(3'b010, 2, 8);
    card_pull = 1'b0;
    i_timeout_route_jumper = 2'b10;
    io(1'b1, 16'h0061, 8'h08);
    // masked: a check event is recorded but no nmi may follow
    card_pull = 1'b1;
    repeat (8) @(negedge i_clock);
    card_pull = 1'b0;
    rd(8'h68);
    cmd(1'b1, 8'h01);
    expect_evt(3'b101, SEC - 4, SEC + 6);
    repeat (10) @(negedge i_clock);
    // short bounce must not reset
    i_reset_button_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_reset_button_n = 1'b1;
    repeat (12) @(negedge i_clock);
    i_reset_button_n = 1'b0;
    expect_evt(3'b100, 4, 14);
    i_reset_button_n = 1'b1;
    repeat (16) @(negedge i_clock);
    i_timeout_route_jumper = 2'b00;
    for (int b = 1; b < 4; b++) begin
      i_boot_timeout_sel = rwd_boot_e'(b);
      do_reset();
      s = 30 * b;
      expect_evt(3'b001, s * SEC - 10, s * SEC + 6);
    end
    test_done();
  end
  initial begin
    #(40 * 20000);
    err_total++;
    test_done();
  end
endmodule : rwd_top_tb

/* pkg/rwd_defs.svh */
// constants for the alarm watchdog and system control port
`ifndef RWD_DEFS_SVH
`define RWD_DEFS_SVH

// system control port address and bit positions
`define RWD_PORT_ADDR 16'h0061
`define RWD_B_GATE 0
`define RWD_B_SPK 1
`define RWD_B_PAR 2
`define RWD_B_CHKMASK 3
`define RWD_B_T2OUT 5
`define RWD_B_CHKSEEN 6
`define RWD_CTL_W 4
`define RWD_CTL_RESET 4'h8

// boot supervision periods in seconds (30, 60, 90)
`define RWD_BOOT_A_SEC 8'h1E
`define RWD_BOOT_B_SEC 8'h3C
`define RWD_BOOT_C_SEC 8'h5A

// timing
`define RWD_CLK_HZ 25000000
`define RWD_SEC_CYC (`RWD_CLK_HZ)
`define RWD_DEBOUNCE_MS 10
`define RWD_DEBOUNCE_CYC ((`RWD_CLK_HZ / 1000) * `RWD_DEBOUNCE_MS)
`define RWD_RST_PULSE_US 100
`define RWD_RST_PULSE_CYC ((`RWD_CLK_HZ / 1000000) * `RWD_RST_PULSE_US)
`define RWD_RST_CNT_W 12

`endif

/* pkg/rwd_pkg.sv */
// types shared by the alarm watchdog modules
package rwd_pkg;
  typedef enum logic [1:0] {RWD_BOOT_OFF, RWD_BOOT_A, RWD_BOOT_B, RWD_BOOT_C} rwd_boot_e;
  typedef enum logic [1:0] {RWD_ROUTE_IRQ, RWD_ROUTE_NMI, RWD_ROUTE_RESET} rwd_route_e;
  typedef enum logic [1:0] {RWD_ST_WAIT1, RWD_ST_WAIT2, RWD_ST_LOAD, RWD_ST_RUN} rwd_boot_st_e;
  typedef logic [7:0] rwd_sec_t;
endpackage : rwd_pkg

/* pkg/rwd_wd_if.sv */
// control link between the watchdog logic and its countdown
`timescale 1ns/10ps
interface rwd_wd_if;
  logic load;
  logic stop;
  rwd_pkg::rwd_sec_t period;
  logic expire;
  logic running;
  modport ctl (output load, output stop, output period, input expire, input running);
  modport cnt (input load, input stop, input period, output expire, output running);
endinterface : rwd_wd_if

/* verilog/rwd_countdown.sv */
// seconds timebase and one-shot watchdog countdown
`timescale 1ns/10ps
`include "rwd_defs.svh"
module rwd_countdown #(
  parameter int unsigned SEC_CYCLES = `RWD_SEC_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // control from the watchdog logic
  rwd_wd_if.cnt wd
);
  import rwd_pkg::*;
  logic [31:0] div, next_div;
  rwd_sec_t cnt, next_cnt;
  logic run, next_run, exp, next_exp;

  always_comb begin
    next_div = div;
    next_cnt = cnt;
    next_run = run;
    next_exp = 1'b0;
    if (wd.load) begin
      // a reload restarts the second as well, so a full period is granted
      next_div = 32'h0000_0000;
      next_cnt = wd.period;
      next_run = (wd.period != 8'h00);
    end else if (wd.stop) begin
      next_run = 1'b0;
    end else if (run) begin
      if (div >= 32'(SEC_CYCLES - 1)) begin
        next_div = 32'h0000_0000;
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_exp = 1'b1;
          next_run = 1'b0;
        end
      end else begin
        next_div = div + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div <= 32'h0000_0000;
      cnt <= 8'h00;
      run <= 1'b0;
      exp <= 1'b0;
    end else begin
      div <= next_div;
      cnt <= next_cnt;
      run <= next_run;
      exp <= next_exp;
    end
  end

  assign wd.expire = exp;
  assign wd.running = run;
endmodule : rwd_countdown

/* verilog/rwd_debounce.sv */
// push-button synchroniser and debouncer
`timescale 1ns/10ps
`include "rwd_defs.svh"
module rwd_debounce #(
  parameter int unsigned CYCLES = `RWD_DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // raw pin, low while pressed
  input wire logic i_button_n,
  // debounced level, high while pressed
  output logic o_pressed
);
  import rwd_pkg::*;
  logic s1, s2, stable, next_stable;
  logic [31:0] cnt, next_cnt;

  always_comb begin
    next_stable = stable;
    next_cnt = 32'h0000_0000;
    // input must hold its new level for the whole window
    if (s2 != stable) begin
      if (cnt >= 32'(CYCLES - 1)) begin
        next_stable = s2;
      end else begin
        next_cnt = cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      stable <= 1'b1;
      cnt <= 32'h0000_0000;
      o_pressed <= 1'b0;
    end else begin
      s1 <= i_button_n;
      s2 <= s1;
      stable <= next_stable;
      cnt <= next_cnt;
      o_pressed <= ~next_stable;
    end
  end
endmodule : rwd_debounce

/* verilog/rwd_top.sv */
// alarm watchdog with timeout routing and system control port
`timescale 1ns/10ps
`include "rwd_defs.svh"
module rwd_top #(
  parameter int unsigned SEC_CYCLES = `RWD_SEC_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = `RWD_DEBOUNCE_CYC,
  parameter int unsigned RST_CYCLES = `RWD_RST_PULSE_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // host i/o cycle, synchronous
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // speaker timer
  input wire logic i_timer2_out,
  output logic o_timer2_gate,
  output logic o_speaker,
  // host watchdog command, synchronous
  input wire logic i_wd_cmd_valid,
  input wire logic i_wd_cmd_enable,
  input wire rwd_pkg::rwd_sec_t i_wd_cmd_seconds,
  output logic o_wd_running,
  // configuration straps and pins
  input wire rwd_pkg::rwd_boot_e i_boot_timeout_sel,
  input wire logic [1:0] i_timeout_route_jumper,
  input wire logic i_reset_button_n,
  // open-drain channel-check line, active low
  input wire logic i_chk_line_n,
  output logic o_chk_line_n,
  output logic o_chk_line_oe,
  // to the processor and system
  output logic o_irq8,
  output logic o_nmi,
  output logic o_sys_reset
);
  import rwd_pkg::*;

  rwd_wd_if wd_bus ();

  rwd_countdown #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_countdown (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .wd(wd_bus.cnt)
  );

  logic button_pressed;

  rwd_debounce #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_button_n(i_reset_button_n),
    .o_pressed(button_pressed)
  );

  // pin synchronisers
  logic [1:0] jmp_s1, jmp_s2;
  rwd_boot_e boot_s1, boot_s2;
  logic chk_s1, chk_s2, chk_d;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      jmp_s1 <= 2'h0;
      jmp_s2 <= 2'h0;
      boot_s1 <= RWD_BOOT_OFF;
      boot_s2 <= RWD_BOOT_OFF;
      chk_s1 <= 1'b1;
      chk_s2 <= 1'b1;
      chk_d <= 1'b1;
    end else begin
      jmp_s1 <= i_timeout_route_jumper;
      jmp_s2 <= jmp_s1;
      boot_s1 <= i_boot_timeout_sel;
      boot_s2 <= boot_s1;
      chk_s1 <= i_chk_line_n;
      chk_s2 <= chk_s1;
      chk_d <= chk_s2;
    end
  end

  rwd_route_e route;

  always_comb begin
    unique case (jmp_s2)
      2'h1: route = RWD_ROUTE_NMI;
      2'h2: route = RWD_ROUTE_RESET;
      // open, or both positions fitted, leaves only the interrupt
      default: route = RWD_ROUTE_IRQ;
    endcase
  end

  rwd_sec_t boot_period;

  always_comb begin
    unique case (boot_s2)
      RWD_BOOT_OFF: boot_period = 8'h00;
      RWD_BOOT_A: boot_period = `RWD_BOOT_A_SEC;
      RWD_BOOT_B: boot_period = `RWD_BOOT_B_SEC;
      RWD_BOOT_C: boot_period = `RWD_BOOT_C_SEC;
    endcase
  end

  // state
  logic [`RWD_CTL_W-1:0] ctl, next_ctl;
  logic chk_seen, next_chk_seen;
  logic nmi_armed, next_nmi_armed;
  logic chk_drive, next_chk_drive;
  logic [`RWD_RST_CNT_W-1:0] rst_cnt, next_rst_cnt;
  rwd_boot_st_e boot_st, next_boot_st;
  logic [7:0] next_rdata;
  logic next_speaker, next_irq8, next_nmi, t2_eff;
  logic io_wr_hit, mask_set, chk_event, expire;

  assign io_wr_hit = i_io_wr && (i_io_addr == `RWD_PORT_ADDR);
  assign mask_set = io_wr_hit && i_io_wdata[`RWD_B_CHKMASK];
  assign chk_event = chk_d && !chk_s2;
  assign expire = wd_bus.expire;

  // countdown control: boot load takes priority over a host command
  always_comb begin
    wd_bus.load = 1'b0;
    wd_bus.stop = 1'b0;
    wd_bus.period = i_wd_cmd_seconds;
    if (boot_st == RWD_ST_LOAD) begin
      wd_bus.load = 1'b1;
      wd_bus.period = boot_period;
    end else if (i_wd_cmd_valid) begin
      wd_bus.load = i_wd_cmd_enable;
      wd_bus.stop = !i_wd_cmd_enable;
    end
  end

  always_comb begin
    next_ctl = ctl;
    next_chk_seen = chk_seen;
    next_nmi_armed = nmi_armed;
    next_chk_drive = chk_drive;
    next_rst_cnt = rst_cnt;
    next_boot_st = boot_st;
    next_nmi = 1'b0;
    next_rdata = o_io_rdata;

    if (io_wr_hit) begin
      next_ctl = i_io_wdata[`RWD_CTL_W-1:0];
    end

    // gate low parks the timer output high
    t2_eff = ctl[`RWD_B_GATE] ? i_timer2_out : 1'b1;
    next_speaker = ctl[`RWD_B_SPK] & t2_eff;

    // alarm always raises the interrupt; only runs while enabled
    next_irq8 = expire;

    // masking clears status and re-arms; a new event in the same cycle wins
    if (mask_set) begin
      next_chk_seen = 1'b0;
      next_nmi_armed = 1'b1;
      next_chk_drive = 1'b0;
    end
    if (chk_event) begin
      next_chk_seen = 1'b1;
    end
    if (expire && route == RWD_ROUTE_NMI) begin
      next_chk_drive = 1'b1;
    end

    // one NMI per arm; mask bit high keeps it off the processor
    if (chk_seen && nmi_armed && !ctl[`RWD_B_CHKMASK] && !mask_set) begin
      next_nmi = 1'b1;
      next_nmi_armed = 1'b0;
    end

    // button and reset route share the same stretched pulse
    if (button_pressed || (expire && route == RWD_ROUTE_RESET)) begin
      next_rst_cnt = `RWD_RST_CNT_W'(RST_CYCLES);
    end else if (rst_cnt != '0) begin
      next_rst_cnt = rst_cnt - `RWD_RST_CNT_W'(1);
    end

    // boot supervision restarts after every system reset pulse
    unique case (boot_st)
      RWD_ST_WAIT1: next_boot_st = RWD_ST_WAIT2;
      RWD_ST_WAIT2: next_boot_st = RWD_ST_LOAD;
      RWD_ST_LOAD: next_boot_st = RWD_ST_RUN;
      RWD_ST_RUN: begin
        if (rst_cnt == `RWD_RST_CNT_W'(1)) begin
          next_boot_st = RWD_ST_LOAD;
        end
      end
    endcase

    if (i_io_rd && i_io_addr == `RWD_PORT_ADDR) begin
      next_rdata = 8'h00;
      next_rdata[`RWD_CTL_W-1:0] = ctl;
      next_rdata[`RWD_B_T2OUT] = t2_eff;
      next_rdata[`RWD_B_CHKSEEN] = chk_seen;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl <= `RWD_CTL_RESET;
      chk_seen <= 1'b0;
      nmi_armed <= 1'b1;
      chk_drive <= 1'b0;
      rst_cnt <= '0;
      boot_st <= RWD_ST_WAIT1;
      o_io_rdata <= 8'h00;
      o_speaker <= 1'b0;
      o_timer2_gate <= 1'b0;
      o_irq8 <= 1'b0;
      o_nmi <= 1'b0;
      o_chk_line_oe <= 1'b0;
      o_sys_reset <= 1'b0;
      o_wd_running <= 1'b0;
    end else begin
      ctl <= next_ctl;
      chk_seen <= next_chk_seen;
      nmi_armed <= next_nmi_armed;
      chk_drive <= next_chk_drive;
      rst_cnt <= next_rst_cnt;
      boot_st <= next_boot_st;
      o_io_rdata <= next_rdata;
      o_speaker <= next_speaker;
      o_timer2_gate <= next_ctl[`RWD_B_GATE];
      o_irq8 <= next_irq8;
      o_nmi <= next_nmi;
      o_chk_line_oe <= next_chk_drive;
      o_sys_reset <= (next_rst_cnt != '0);
      o_wd_running <= wd_bus.running;
    end
  end

  // open drain: only ever pulls low
  assign o_chk_line_n = 1'b0;
endmodule : rwd_top
